// File: tb_temp_sensor_config_and_limit_output.sv
`timescale 1ns/1ps

// ****
// Bench
// ****
module tb_temp_sensor_config_and_limit_output;
   localparam TK = 20;
   reg          clk;
   reg          nrst;
   reg  [11:0]  adc_data;
   wire         ptr_wr;
   wire [1:0]   ptr_wdata;
   wire         reg_wr;
   wire [15:0]  reg_wdata;
   wire         reg_rd_done;
   wire [15:0]  reg_rdata;
   wire [1:0]   ptr;
   wire         alert_pin;
   wire         conv_active;
   wire         temp_valid;
   wire         dev_ready;
   reg  [15:0]  rv;
   integer      err_count;
   integer      checks;
   integer      cyc;
   integer      n;

   tsc_host_model u_host (.clk(clk), .reg_rdata(reg_rdata), .ptr_wr(ptr_wr),
      .ptr_wdata(ptr_wdata), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd_done(reg_rd_done));
   tsc_top #(.TICK_CYCLES(TK)) u_dut (.clk(clk), .nrst(nrst), .ptr_wr(ptr_wr),
      .ptr_wdata(ptr_wdata), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd_done(reg_rd_done),
      .adc_data(adc_data), .reg_rdata(reg_rdata), .ptr(ptr), .alert_pin(alert_pin),
      .conv_active(conv_active), .temp_valid(temp_valid), .dev_ready(dev_ready));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task summarize;
      begin
         if (err_count == 0 && checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask

   task chk(input [8*12-1:0] nm, input [15:0] e, input [15:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("MISMATCH %0s exp %h got %h", nm, e, g);
         end
      end
   endtask

   task chk1(input [8*12-1:0] nm, input e, input g);
      chk(nm, {15'h0, e}, {15'h0, g});
   endtask

   task wait_conv(input want, input integer lim);
      begin
         for (n = 0; n < lim && conv_active !== want; n = n + 1)
            @(posedge clk);
         chk1("conv_wait", want, conv_active);
      end
   endtask

   task shot(input [11:0] adc, input [7:0] b);
      begin
         @(posedge clk) adc_data <= adc;
         repeat (4) @(posedge clk);
         u_host.wr(2'h1, {8'h00, b | 8'h81});
         wait_conv(1'b1, 6);
         wait_conv(1'b0, 240 * TK + 60);
         repeat (6) @(posedge clk);
         #1;
      end
   endtask

   task t_defaults;
      integer i;
      begin
         chk("ptr_por", 16'h0000, {14'h0, ptr});
         chk1("tv_por", 1'b0, temp_valid);
         for (i = 0; i < 4; i = i + 1) begin
            u_host.rd(i[1:0], rv);
            chk("por_reg", (i == 2) ? 16'h9600 : (i == 3) ? 16'ha000 : 16'h0000, rv);
         end
      end
   endtask

   task t_ignore;
      begin
         u_host.wr(2'h1, 16'h0080);
         repeat (3) @(posedge clk);
         #1 chk1("conv_on", 1'b1, conv_active);
         u_host.rd(2'h1, rv);
         chk("cfg_80", 16'h0080, rv);
      end
   endtask

   task t_limits;
      begin
         u_host.wr(2'h1, 16'h0001);
         repeat (3) @(posedge clk);
         #1 chk1("conv_off", 1'b0, conv_active);
         u_host.wr(2'h3, 16'hffff);
         u_host.rd(2'h3, rv);
         chk("upper_ff", 16'hff80, rv);
         u_host.wr(2'h3, 16'h197f);
         u_host.wr(2'h2, 16'h1400);
         u_host.rd(2'h3, rv);
         chk("upper", 16'h1900, rv);
         u_host.rd(2'h2, rv);
         chk("lower", 16'h1400, rv);
      end
   endtask

   task t_res;
      integer r;
      begin
         for (r = 0; r < 4; r = r + 1) begin
            u_host.wr(2'h1, {9'h000, r[1:0], 5'h01});
            shot(12'h197, {1'b0, r[1:0], 5'h01});
            chk1("tv_set", 1'b1, temp_valid);
            u_host.rd(2'h0, rv);
            chk("temp_res", 16'h1970 & ~(16'h007f >> r), rv);
            u_host.rd(2'h1, rv);
            chk("cfg_clr", {9'h000, r[1:0], 5'h01}, rv);
         end
      end
   endtask

   // Long wait in continuous mode, below the lower limit, clears a comparator alert
   task settle(input [1:0] c);
      begin
         @(posedge clk) adc_data <= 12'h100;
         u_host.wr(2'h1, {11'h000, c, 3'h0});
         repeat ((2 * c + 4) * 620) @(posedge clk);
         #1 chk1("alert_off", 1'b1, alert_pin);
      end
   endtask

   task t_comp;
      integer c;
      integer i;
      integer d;
      reg [7:0] b;
      begin
         settle(2'h0);
         for (c = 0; c < 4; c = c + 1) begin
            b = {3'h0, c[1:0], 3'h1};
            d = (c == 0) ? 1 : 2 * c;
            u_host.wr(2'h1, {8'h00, b});
            for (i = 1; i < d; i = i + 1)
               shot(12'h1a0, b);
            shot(12'h170, b);
            for (i = 1; i < d; i = i + 1)
               shot(12'h1a0, b);
            chk1("alert_wait", 1'b1, alert_pin);
            shot(12'h1a0, b);
            chk1("alert_on", 1'b0, alert_pin);
            for (i = 0; i < d; i = i + 1)
               shot(12'h100, b);
            chk1("alert_hold", 1'b0, alert_pin);
            settle(c[1:0]);
         end
      end
   endtask

   task t_int;
      begin
         u_host.wr(2'h1, 16'h0007);
         repeat (3) @(posedge clk);
         #1 chk1("pol_high", 1'b0, alert_pin);
         shot(12'h1a0, 8'h07);
         chk1("int_up", 1'b1, alert_pin);
         u_host.rd(2'h1, rv);
         chk("cfg_int", 16'h0007, rv);
         repeat (2) @(posedge clk);
         #1 chk1("int_rd", 1'b0, alert_pin);
         shot(12'h1a0, 8'h07);
         chk1("int_again", 1'b0, alert_pin);
         shot(12'h100, 8'h07);
         chk1("int_low", 1'b1, alert_pin);
         u_host.rd(2'h0, rv);
         chk("temp_low", 16'h1000, rv);
         repeat (2) @(posedge clk);
         #1 chk1("int_rd2", 1'b0, alert_pin);
         @(posedge clk) adc_data <= 12'h1a0;
         u_host.wr(2'h1, 16'h0006);
         repeat (1300) @(posedge clk);
         #1 chk1("int_cont", 1'b1, alert_pin);
         u_host.wr(2'h1, 16'h0007);
         repeat (3) @(posedge clk);
         #1 chk1("int_shdn", 1'b0, alert_pin);
      end
   endtask

   // Hang guard: about one and a half times the expected run length
   initial cyc = 0;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 90000) begin
         err_count = err_count + 1;
         summarize;
      end
   end

   initial begin
      nrst      = 1'b0;
      adc_data  = 12'h000;
      err_count = 0;
      checks    = 0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      u_host.wr(2'h1, 16'h00ff);
      for (n = 0; n < 200 && dev_ready !== 1'b1; n = n + 1)
         @(posedge clk);
      chk1("ready", 1'b1, dev_ready);
      t_defaults;
      t_ignore;
      t_limits;
      t_res;
      t_comp;
      t_int;
      summarize;
   end
endmodule // tb_temp_sensor_config_and_limit_output

// File: tsc_defs.vh
`ifndef TSC_DEFS_VH
`define TSC_DEFS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define TSC_CLK_NS        50
`define TSC_TICK_NS       1000000
`define TSC_PWRUP_MS      8'd2
`define TSC_CONV_MS_9     8'd30
`define TSC_CONV_MS_10    8'd60
`define TSC_CONV_MS_11    8'd120
`define TSC_CONV_MS_12    8'd240
`define TSC_MS_W          8

// ****************************************************************
// Register pointer codes
// ****************************************************************
`define TSC_PTR_TEMP      2'h0
`define TSC_PTR_CFG       2'h1
`define TSC_PTR_HYST      2'h2
`define TSC_PTR_LIMIT     2'h3

// ****************************************************************
// Configuration fields
// ****************************************************************
`define TSC_CFG_ONESHOT   7
`define TSC_CFG_RES_HI    6
`define TSC_CFG_RES_LO    5
`define TSC_CFG_FQ_HI     4
`define TSC_CFG_FQ_LO     3
`define TSC_CFG_POL       2
`define TSC_CFG_MODE      1
`define TSC_CFG_SHDN      0

`define TSC_RES_9         2'h0
`define TSC_RES_10        2'h1
`define TSC_RES_11        2'h2
`define TSC_RES_12        2'h3

`define TSC_MASK_9        12'hff8
`define TSC_MASK_10       12'hffc
`define TSC_MASK_11       12'hffe
`define TSC_MASK_12       12'hfff

`define TSC_FQ_1          3'h1
`define TSC_FQ_2          3'h2
`define TSC_FQ_4          3'h4
`define TSC_FQ_6          3'h6

// ****************************************************************
// Limit field and reset values
// ****************************************************************
`define TSC_LIM_MSB       15
`define TSC_LIM_LSB       7
`define TSC_TEMP_RST      16'h0000
`define TSC_LIMIT_RST     16'ha000
`define TSC_HYST_RST      16'h9600
`define TSC_CFG_RST       8'h00
`define TSC_PTR_RST       2'h0

`endif

// File: tsc_fault_queue.v
`timescale 1ns/1ps

// ****************************************************************
// Consecutive-conversion filter
// ****************************************************************
module tsc_fault_queue #(
   parameter W = 3
) (
   input  wire         clk,
   input  wire         nrst,
   input  wire         sample,
   input  wire         cond,
   input  wire [W-1:0] depth,
   output reg          met,
   output reg          fire
);
   reg  [W-1:0] cnt;
   wire [W-1:0] inc = cnt + {{(W-1){1'b0}}, 1'b1};

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt  <= {W{1'b0}};
         met  <= 1'b0;
         fire <= 1'b0;
      end else begin
         fire <= 1'b0;
         if (sample) begin
            if (!cond) begin
               cnt <= {W{1'b0}};
               met <= 1'b0;
            end else if (cnt < depth) begin
               cnt <= inc;
               // Fires once on reaching the depth, then saturates
               met  <= (inc >= depth);
               fire <= (inc == depth);
            end
         end
      end
   end
endmodule // tsc_fault_queue

// File: tsc_host_model.sv
`timescale 1ns/1ps

// ****
// Bus master model
// ****
module tsc_host_model (
   input  wire        clk,
   input  wire [15:0] reg_rdata,
   output reg         ptr_wr,
   output reg  [1:0]  ptr_wdata,
   output reg         reg_wr,
   output reg  [15:0] reg_wdata,
   output reg         reg_rd_done
);
   initial begin
      ptr_wr      = 1'b0;
      ptr_wdata   = 2'h0;
      reg_wr      = 1'b0;
      reg_wdata   = 16'h0000;
      reg_rd_done = 1'b0;
   end

   // Released data lines carry the inverse so stale values never look valid
   task wr(input [1:0] p, input [15:0] d);
      begin
         @(posedge clk);
         ptr_wr    <= 1'b1;
         ptr_wdata <= p;
         @(posedge clk);
         ptr_wr    <= 1'b0;
         ptr_wdata <= ~p;
         reg_wr    <= 1'b1;
         reg_wdata <= d;
         @(posedge clk);
         reg_wr    <= 1'b0;
         reg_wdata <= ~d;
      end
   endtask

   // Every completed read is reported, as a real master always finishes it
   task rd(input [1:0] p, output [15:0] d);
      begin
         @(posedge clk);
         ptr_wr    <= 1'b1;
         ptr_wdata <= p;
         @(posedge clk);
         ptr_wr    <= 1'b0;
         ptr_wdata <= ~p;
         repeat (2) @(posedge clk);
         d = reg_rdata;
         reg_rd_done <= 1'b1;
         @(posedge clk);
         reg_rd_done <= 1'b0;
      end
   endtask
endmodule // tsc_host_model

// File: tsc_properties.sv
`timescale 1ns/1ps

// ****
// Limit and mode checks
// ****
module tsc_props #(
   parameter TICK_CYCLES = 20,
   parameter TICK_W      = 15
) (
   input wire        clk,
   input wire        nrst,
   input wire        ptr_wr,
   input wire [1:0]  ptr_wdata,
   input wire        reg_wr,
   input wire [15:0] reg_wdata,
   input wire        reg_rd_done,
   input wire [11:0] adc_data,
   input wire [15:0] reg_rdata,
   input wire [1:0]  ptr,
   input wire        alert_pin,
   input wire        conv_active,
   input wire        temp_valid,
   input wire        dev_ready
);
   // Shadow of host config writes; misses the hardware clear of bit 7
   reg  [7:0]  cfg_sh;
   reg  [31:0] run;
   reg  [31:0] up_cnt;
   wire        cfg_wr   = reg_wr && ptr == 2'h1 && dev_ready;
   wire [31:0] conv_cyc = (32'd30 << cfg_sh[6:5]) * TICK_CYCLES;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_sh <= 8'h00;
         run    <= 32'h0;
         up_cnt <= 32'h0;
      end else begin
         if (cfg_wr)
            cfg_sh <= reg_wdata[7:0];
         run <= conv_active ? run + 32'h1 : 32'h0;
         if (!dev_ready)
            up_cnt <= up_cnt + 32'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_shot_req;
      cfg_wr && reg_wdata[0] && reg_wdata[7] && cfg_sh[0] && !conv_active;
   endsequence
   sequence s_shot_run;
      ##[1:2] conv_active;
   endsequence

   property p_pre_ready;
      !dev_ready |-> alert_pin && !conv_active && !temp_valid;
   endproperty
   a_pre_ready: assert property (p_pre_ready) else $error("early state");
   property p_ready_time;
      $rose(dev_ready) |-> up_cnt + 2 >= 2 * TICK_CYCLES && up_cnt <= 2 * TICK_CYCLES + 8;
   endproperty
   a_ready_time: assert property (p_ready_time) else $error("wait length");
   property p_ready_hold;
      dev_ready |=> dev_ready;
   endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
   property p_temp_low;
      ptr == 2'h0 && $stable(ptr) |-> reg_rdata[3:0] == 4'h0;
   endproperty
   a_temp_low: assert property (p_temp_low) else $error("temp low bits");
   property p_lim_low;
      ptr[1] && $stable(ptr) |-> reg_rdata[6:0] == 7'h00;
   endproperty
   a_lim_low: assert property (p_lim_low) else $error("limit low bits");
   property p_shdn;
      cfg_wr && reg_wdata[0] && !reg_wdata[7] |-> ##[1:2] !conv_active;
   endproperty
   a_shdn: assert property (p_shdn) else $error("no stop");
   property p_shdn_stay;
      cfg_sh[0] && !cfg_sh[7] && !conv_active && !cfg_wr |=> !conv_active;
   endproperty
   a_shdn_stay: assert property (p_shdn_stay) else $error("left stop");
   property p_shot_go;
      s_shot_req |-> s_shot_run;
   endproperty
   a_shot_go: assert property (p_shot_go) else $error("no shot");
   property p_shot_len;
      $fell(conv_active) && cfg_sh[7] |-> run + TICK_CYCLES >= conv_cyc && run <= conv_cyc + 8;
   endproperty
   a_shot_len: assert property (p_shot_len) else $error("conv length");
   property p_int_clear;
      cfg_sh[1] && reg_rd_done |=> alert_pin != cfg_sh[2];
   endproperty
   a_int_clear: assert property (p_int_clear) else $error("read kept alert");
   property p_pol;
      cfg_wr && reg_wdata[2] != cfg_sh[2] |-> ##[1:2] $changed(alert_pin);
   endproperty
   a_pol: assert property (p_pol) else $error("polarity");
   property p_int_shdn;
      cfg_sh[1] && !cfg_sh[0] && cfg_wr && reg_wdata[1] && reg_wdata[0]
         |-> ##[1:3] alert_pin != cfg_sh[2];
   endproperty
   a_int_shdn: assert property (p_int_shdn) else $error("stop kept alert");
endmodule // tsc_props

bind tsc_top tsc_props #(.TICK_CYCLES(TICK_CYCLES), .TICK_W(TICK_W)) u_props (
   .clk(clk), .nrst(nrst), .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd_done(reg_rd_done), .adc_data(adc_data),
   .reg_rdata(reg_rdata), .ptr(ptr), .alert_pin(alert_pin), .conv_active(conv_active),
   .temp_valid(temp_valid), .dev_ready(dev_ready));

// File: tsc_tick_div.v
`timescale 1ns/1ps

// ****************************************************************
// Millisecond tick divider
// ****************************************************************
module tsc_tick_div #(
   parameter CYCLES = 20000,
   parameter W      = 15
) (
   input  wire clk,
   input  wire nrst,
   input  wire clr,
   output reg  tick
);
   reg [W-1:0] cnt;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt  <= {W{1'b0}};
         tick <= 1'b0;
      end else if (clr) begin
         cnt  <= {W{1'b0}};
         tick <= 1'b0;
      end else if (cnt == CYCLES[W-1:0] - {{(W-1){1'b0}}, 1'b1}) begin
         cnt  <= {W{1'b0}};
         tick <= 1'b1;
      end else begin
         cnt  <= cnt + {{(W-1){1'b0}}, 1'b1};
         tick <= 1'b0;
      end
   end
endmodule // tsc_tick_div

// File: tsc_top.v
// Overview of operation
// - Config bit 7 requests a single conversion; clear after power-up.
// - Config bits 6:5 select 9, 10, 11 or 12 bit resolution.
// - Config bits 4:3 select fault queue of 1, 2, 4 or 6 conversions.
// - Config bit 2 sets limit output polarity, 1 active-high, default low.
// - Config bit 1 selects interrupt (1) or comparator (0) behaviour.
// - Config bit 0 stops continuous conversion; register access keeps working.
// - Shutdown holds until continuous is written back or power-on reset.
// - All registers stay readable and writable during shutdown.
// - Single conversion takes conversion time, updates temp, clears bit 7, shuts down.
// - Bit 7 set with bit 0 clear is ignored; conversion continues.
// - Comparator: assert above upper limit, hold until below lower limit.
// - Comparator: held through shutdown; clears only in continuous mode.
// - Interrupt: assert above upper limit, cleared by any register read.
// - Interrupt: after upper event, assert again below lower limit.
// - Interrupt: entering shutdown from continuous mode deasserts the limit output.
// - Upper event needs the selected count of consecutive conversions.
// - Same count applies below the lower limit.
// - Conversion takes 30, 60, 120 or 240 ms by resolution.
// - Power-on defaults: temp 0000, upper A000, lower 9600, pointer and config 00.
// - Wait 2 ms after power-up, then start; temp valid after one conversion.
// - Limit registers hold nine upper bits; lower bits read zero.
// - Unused low result bits read zero below 12-bit resolution.
`timescale 1ns/1ps
`include "tsc_defs.vh"

module tsc_top #(
   parameter TICK_CYCLES = `TSC_TICK_NS / `TSC_CLK_NS,
   parameter TICK_W      = 15
) (
   input  wire        clk,
   input  wire        nrst,
   input  wire        ptr_wr,
   input  wire [1:0]  ptr_wdata,
   input  wire        reg_wr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_rd_done,
   input  wire [11:0] adc_data,
   output reg  [15:0] reg_rdata,
   output reg  [1:0]  ptr,
   output reg         alert_pin,
   output reg         conv_active,
   output reg         temp_valid,
   output reg         dev_ready
);

   // ****************************************************************
   // States
   // ****************************************************************
   localparam ST_PWRUP = 2'h0;
   localparam ST_CONV  = 2'h1;
   localparam ST_SHDN  = 2'h2;

   // Reset images as vectors, so the limit field can be sliced out of them
   localparam [15:0] LIMIT_RST = `TSC_LIMIT_RST;
   localparam [15:0] HYST_RST  = `TSC_HYST_RST;

   reg  [1:0]             state;
   reg  [1:0]             next_state;
   reg  [`TSC_MS_W-1:0]   ms_cnt;
   reg                    oneshot_run;
   reg                    next_oneshot_run;
   reg                    tick_clr;
   reg                    conv_done;
   reg  [7:0]             cfg;
   reg  [15:0]            temp;
   reg  [8:0]             limit9;
   reg  [8:0]             hyst9;
   reg                    alert_act;
   reg                    int_wait_low;
   reg  [11:0]            adc_meta;
   reg  [11:0]            adc_sync;

   reg  [`TSC_MS_W-1:0]   conv_ms;
   reg  [11:0]            res_mask;
   reg  [2:0]             fq_depth;
   reg                    next_alert;

   wire                   tick;
   wire                   over_met;
   wire                   over_fire;
   wire                   under_met;
   wire                   under_fire;

   wire [1:0] res_sel   = cfg[`TSC_CFG_RES_HI:`TSC_CFG_RES_LO];
   wire [1:0] fq_sel    = cfg[`TSC_CFG_FQ_HI:`TSC_CFG_FQ_LO];
   wire       int_mode  = cfg[`TSC_CFG_MODE];
   wire       shdn_bit  = cfg[`TSC_CFG_SHDN];
   wire       os_bit    = cfg[`TSC_CFG_ONESHOT];
   wire       wr_ok     = reg_wr & dev_ready;
   wire       wr_cfg    = wr_ok & (ptr == `TSC_PTR_CFG);
   wire       wr_limit  = wr_ok & (ptr == `TSC_PTR_LIMIT);
   wire       wr_hyst   = wr_ok & (ptr == `TSC_PTR_HYST);
   wire       period_end = tick & (ms_cnt == conv_ms - {{(`TSC_MS_W-1){1'b0}}, 1'b1});
   wire       pwrup_end  = tick & (ms_cnt == `TSC_PWRUP_MS - {{(`TSC_MS_W-1){1'b0}}, 1'b1});
   wire       shdn_enter = (state == ST_CONV) & (next_state == ST_SHDN) & ~oneshot_run;
   wire       os_finish  = (state == ST_CONV) & oneshot_run & period_end;
   wire       continuous = (state == ST_CONV) & ~oneshot_run;

   // ****************************************************************
   // Converter result synchroniser
   // ****************************************************************
   // Result is held steady by the converter around the sampling edge
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         adc_meta <= 12'h000;
         adc_sync <= 12'h000;
      end else begin
         adc_meta <= adc_data;
         adc_sync <= adc_meta;
      end
   end

   // ****************************************************************
   // Field decode
   // ****************************************************************
   always @* begin
      case (res_sel)
         `TSC_RES_9: begin
            conv_ms  = `TSC_CONV_MS_9;
            res_mask = `TSC_MASK_9;
         end
         `TSC_RES_10: begin
            conv_ms  = `TSC_CONV_MS_10;
            res_mask = `TSC_MASK_10;
         end
         `TSC_RES_11: begin
            conv_ms  = `TSC_CONV_MS_11;
            res_mask = `TSC_MASK_11;
         end
         default: begin
            conv_ms  = `TSC_CONV_MS_12;
            res_mask = `TSC_MASK_12;
         end
      endcase
   end

   always @* begin
      case (fq_sel)
         2'h0:    fq_depth = `TSC_FQ_1;
         2'h1:    fq_depth = `TSC_FQ_2;
         2'h2:    fq_depth = `TSC_FQ_4;
         default: fq_depth = `TSC_FQ_6;
      endcase
   end

   // ****************************************************************
   // Millisecond time base
   // ****************************************************************
   // Restarted on every phase so each period is a whole number of ms
   tsc_tick_div #(
      .CYCLES (TICK_CYCLES),
      .W      (TICK_W)
   ) u_tick (
      .clk  (clk),
      .nrst (nrst),
      .clr  (tick_clr),
      .tick (tick)
   );

   // ****************************************************************
   // Operating mode sequencer
   // ****************************************************************
   always @* begin
      next_state       = state;
      next_oneshot_run = oneshot_run;
      case (state)
         ST_PWRUP: begin
            if (pwrup_end)
               next_state = ST_CONV;
         end
         ST_CONV: begin
            if (oneshot_run) begin
               if (period_end) begin
                  next_state       = ST_SHDN;
                  next_oneshot_run = 1'b0;
               end
            end else if (shdn_bit) begin
               next_state = ST_SHDN;
            end
         end
         ST_SHDN: begin
            if (!shdn_bit) begin
               next_state = ST_CONV;
            end else if (os_bit) begin
               next_state       = ST_CONV;
               next_oneshot_run = 1'b1;
            end
         end
         default: begin
            next_state       = ST_PWRUP;
            next_oneshot_run = 1'b0;
         end
      endcase
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state       <= ST_PWRUP;
         oneshot_run <= 1'b0;
         ms_cnt      <= {`TSC_MS_W{1'b0}};
         tick_clr    <= 1'b1;
         conv_done   <= 1'b0;
         conv_active <= 1'b0;
         dev_ready   <= 1'b0;
         temp_valid  <= 1'b0;
      end else begin
         state       <= next_state;
         oneshot_run <= next_oneshot_run;
         conv_active <= (next_state == ST_CONV);
         conv_done   <= (state == ST_CONV) & period_end;
         if (pwrup_end)
            dev_ready <= 1'b1;
         if ((state == ST_CONV) & period_end)
            temp_valid <= 1'b1;
         if ((next_state != state) || (state == ST_CONV && period_end)) begin
            ms_cnt   <= {`TSC_MS_W{1'b0}};
            tick_clr <= 1'b1;
         end else begin
            tick_clr <= 1'b0;
            // A tick issued just before the divider restart must not count
            if (tick & ~tick_clr)
               ms_cnt <= ms_cnt + {{(`TSC_MS_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ptr    <= `TSC_PTR_RST;
         cfg    <= `TSC_CFG_RST;
         temp   <= `TSC_TEMP_RST;
         limit9 <= LIMIT_RST[`TSC_LIM_MSB:`TSC_LIM_LSB];
         hyst9  <= HYST_RST[`TSC_LIM_MSB:`TSC_LIM_LSB];
      end else begin
         if (ptr_wr & dev_ready)
            ptr <= ptr_wdata;
         if ((state == ST_CONV) & period_end)
            temp <= {adc_sync & res_mask, 4'h0};
         // A one-shot written without prior shutdown is dropped
         if (os_finish | shdn_enter)
            cfg[`TSC_CFG_ONESHOT] <= 1'b0;
         // Host write lands after the self-clear, so a new request wins
         if (wr_cfg)
            cfg <= reg_wdata[7:0];
         if (wr_limit)
            limit9 <= reg_wdata[`TSC_LIM_MSB:`TSC_LIM_LSB];
         if (wr_hyst)
            hyst9 <= reg_wdata[`TSC_LIM_MSB:`TSC_LIM_LSB];
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= `TSC_TEMP_RST;
      end else begin
         case (ptr)
            `TSC_PTR_TEMP:  reg_rdata <= temp;
            `TSC_PTR_CFG:   reg_rdata <= {8'h00, cfg};
            `TSC_PTR_HYST:  reg_rdata <= {hyst9, 7'h00};
            default:        reg_rdata <= {limit9, 7'h00};
         endcase
      end
   end

   // ****************************************************************
   // Limit comparison and fault queues
   // ****************************************************************
   // Both limits are widened to the result's twelve bits with a zero fraction
   wire over_lim  = $signed(temp[15:4]) > $signed({limit9, 3'h0});
   wire under_lim = $signed(temp[15:4]) < $signed({hyst9, 3'h0});

   // Both queues sample one cycle after the result register loads
   tsc_fault_queue #(
      .W (3)
   ) u_fq_over (
      .clk    (clk),
      .nrst   (nrst),
      .sample (conv_done),
      .cond   (over_lim),
      .depth  (fq_depth),
      .met    (over_met),
      .fire   (over_fire)
   );

   tsc_fault_queue #(
      .W (3)
   ) u_fq_under (
      .clk    (clk),
      .nrst   (nrst),
      .sample (conv_done),
      .cond   (under_lim),
      .depth  (fq_depth),
      .met    (under_met),
      .fire   (under_fire)
   );

   // ****************************************************************
   // Limit output
   // ****************************************************************
   always @* begin
      next_alert = alert_act;
      if (!int_mode) begin
         if (over_met)
            next_alert = 1'b1;
         else if (under_met & continuous)
            next_alert = 1'b0;
      end else begin
         // A one-shot falling back to shutdown leaves a pending interrupt alone
         if (reg_rd_done | shdn_enter)
            next_alert = 1'b0;
         // A new event beats a read finishing in the same cycle
         if (over_fire & ~int_wait_low)
            next_alert = 1'b1;
         else if (under_fire & int_wait_low)
            next_alert = 1'b1;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         alert_act    <= 1'b0;
         int_wait_low <= 1'b0;
         alert_pin    <= 1'b1;
      end else begin
         alert_act <= next_alert;
         if (int_mode & over_fire & ~int_wait_low)
            int_wait_low <= 1'b1;
         else if (int_mode & under_fire & int_wait_low)
            int_wait_low <= 1'b0;
         alert_pin <= cfg[`TSC_CFG_POL] ? next_alert : ~next_alert;
      end
   end

endmodule // tsc_top
